//--- hdl/swc_servo_axis.sv
// Error counter, speed output and power-up wiring check for one servo axis.
`timescale 1ns/100ps

module swc_servo_axis #(
  parameter int COUNT_W = swc_pkg::COUNT_W,
  parameter int OUT_W = swc_pkg::OUT_W
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic phaseA,
  input wire logic phaseB,
  input swc_pkg::swc_cfg_t cfg,
  output logic signed [OUT_W-1:0] speedOut,
  output logic servoLock,
  output logic reverseError,
  output logic disconnectError,
  output logic testDone
);
  import swc_pkg::*;

  if (COUNT_W != swc_pkg::COUNT_W || OUT_W < 2 || OUT_W > COUNT_W) begin : gen_width_check
    $error("Unsupported counter or output width.");
  end

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic rstSync1;
  logic rstN;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync1 <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstN <= rstSync1;
    end
  end

  // ==========================================================================
  // Feedback decoding
  // ==========================================================================
  logic fbStep;
  logic fbUp;

  swc_quad_decoder decoder (
    .clk(mclk),
    .rstN(rstN),
    .phaseA(phaseA),
    .phaseB(phaseB),
    .invert(cfg.encoderInvert),
    .step(fbStep),
    .stepUp(fbUp)
  );

  // ==========================================================================
  // Sequence state
  // ==========================================================================
  swc_state_t state;
  swc_state_t next_state;
  logic signed [COUNT_W-1:0] errCount;
  logic signed [COUNT_W-1:0] next_errCount;
  logic [WAIT_W-1:0] waitCount;
  logic [COUNT_W-1:0] fbTally;
  logic wrongDir;
  logic signed [COUNT_W-1:0] loadValue;
  logic signed [COUNT_W-1:0] stepDelta;
  logic inLoop;
  logic waitOver;
  logic evalReverse;
  logic evalMissing;
  logic signed [OUT_W-1:0] next_speedOut;
  logic signed [COUNT_W-1:0] maxOut;
  logic signed [COUNT_W-1:0] minOut;

  assign loadValue = cfg.testDirCcw ? -$signed(cfg.testPulses) : $signed(cfg.testPulses);
  assign stepDelta = !fbStep ? RESET_COUNT : (fbUp ? 24'sh000001 : -24'sh000001);
  assign inLoop = (state == SWC_WAIT) || (state == SWC_RUN);
  assign waitOver = waitCount >= cfg.waitCycles;
  // Reverse when feedback opposes test direction.
  assign evalReverse = wrongDir;
  assign evalMissing = !wrongDir && (fbTally < cfg.testPulses);
  assign maxOut = COUNT_W'((1 <<< (OUT_W - 1)) - 1);
  assign minOut = -maxOut;

  always_comb begin
    next_state = state;
    case (state)
      SWC_IDLE: begin
        next_state = cfg.checkEnable ? SWC_LOAD : SWC_RUN;
      end
      SWC_LOAD: begin
        next_state = SWC_WAIT;
      end
      SWC_WAIT: begin
        if (waitOver) begin
          next_state = SWC_EVAL;
        end
      end
      SWC_EVAL: begin
        next_state = (evalReverse || evalMissing) ? SWC_FAULT : SWC_RUN;
      end
      SWC_RUN: next_state = SWC_RUN;
      SWC_FAULT: next_state = SWC_FAULT;
      default: next_state = SWC_IDLE;
    endcase
  end

  always_comb begin
    next_errCount = errCount;
    if (state == SWC_LOAD) begin
      next_errCount = loadValue;
    end else if (inLoop) begin
      // Returning feedback drives count back to zero.
      next_errCount = errCount - stepDelta;
    end else if (state == SWC_FAULT) begin
      next_errCount = RESET_COUNT;
    end
  end

  always_comb begin
    next_speedOut = ZERO_VOLT;
    if (inLoop) begin
      if ((errCount >>> GAIN_SHIFT) > maxOut) begin
        next_speedOut = maxOut[OUT_W-1:0];
      end else if ((errCount >>> GAIN_SHIFT) < minOut) begin
        next_speedOut = minOut[OUT_W-1:0];
      end else begin
        next_speedOut = OUT_W'(errCount >>> GAIN_SHIFT);
      end
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      state <= SWC_IDLE;
      errCount <= RESET_COUNT;
      waitCount <= '0;
      fbTally <= RESET_COUNT;
      wrongDir <= 1'b0;
    end else begin
      state <= next_state;
      errCount <= next_errCount;
      waitCount <= (state == SWC_WAIT) ? waitCount + 1'b1 : '0;
      if (state == SWC_WAIT && fbStep) begin
        if (fbUp == cfg.testDirCcw) begin
          wrongDir <= 1'b1;
        end else if (fbTally != {COUNT_W{1'b1}}) begin
          fbTally <= fbTally + 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      speedOut <= ZERO_VOLT;
      servoLock <= 1'b0;
      reverseError <= 1'b0;
      disconnectError <= 1'b0;
      testDone <= 1'b0;
    end else begin
      speedOut <= next_speedOut;
      servoLock <= (next_state == SWC_WAIT) || (next_state == SWC_RUN);
      testDone <= testDone || (state == SWC_EVAL) || (state == SWC_RUN);
      if (state == SWC_EVAL) begin
        reverseError <= reverseError || evalReverse;
        disconnectError <= disconnectError || evalMissing;
      end
    end
  end

endmodule

//--- hdl/swc_pkg.sv
// Package with shared constants and types for the servo loop wiring check.
package swc_pkg;

  // ==========================================================================
  // Widths and defaults
  // ==========================================================================
  localparam int COUNT_W = 24;
  localparam int OUT_W = 16;
  localparam int WAIT_W = 32;
  localparam logic [COUNT_W-1:0] RESET_COUNT = 24'h000000;
  localparam logic [OUT_W-1:0] ZERO_VOLT = 16'h0000;
  localparam logic [1:0] RESET_PHASE = 2'h0;
  localparam logic CHECK_ENABLE_DEFAULT = 1'b1;
  localparam logic POLARITY_DEFAULT = 1'b0;
  localparam int GAIN_SHIFT = 0;

  // ==========================================================================
  // Wiring test sequence states
  // ==========================================================================
  typedef enum logic [2:0] {
    SWC_IDLE = 3'h0,
    SWC_LOAD = 3'h1,
    SWC_WAIT = 3'h3,
    SWC_EVAL = 3'h2,
    SWC_RUN = 3'h6,
    SWC_FAULT = 3'h7
  } swc_state_t;

  // ==========================================================================
  // Configuration and status carriers
  // ==========================================================================
  typedef struct packed {
    logic checkEnable;
    logic testDirCcw;
    logic encoderInvert;
    logic [COUNT_W-1:0] testPulses;
    logic [WAIT_W-1:0] waitCycles;
  } swc_cfg_t;

  typedef struct packed {
    logic servoLock;
    logic reverseError;
    logic disconnectError;
    logic testDone;
  } swc_status_t;

endpackage

//--- hdl/swc_quad_decoder.sv
// Quadrature decoder that turns phase A and B edges into signed count steps.
`timescale 1ns/100ps

module swc_quad_decoder (
  input wire logic clk,
  input wire logic rstN,
  input wire logic phaseA,
  input wire logic phaseB,
  input wire logic invert,
  output logic step,
  output logic stepUp
);
  import swc_pkg::*;

  logic [1:0] prevPhase;
  logic [1:0] currPhase;
  logic changed;
  logic forward;
  logic legal;

  assign currPhase = {phaseA, phaseB};
  assign changed = currPhase != prevPhase;
  assign legal = changed && (currPhase != ~prevPhase);
  assign forward = (prevPhase[1] ^ currPhase[0]);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      prevPhase <= RESET_PHASE;
      step <= 1'b0;
      stepUp <= 1'b0;
    end else begin
      prevPhase <= currPhase;
      step <= legal;
      stepUp <= forward ^ invert;
    end
  end

endmodule

//--- test/swc_servo_axis_sva.sv
// Port checks for the servo axis.
`timescale 1ns/100ps
module swc_servo_axis_sva #(
  parameter int OUT_W = swc_pkg::OUT_W
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic phaseA,
  input wire logic phaseB,
  input swc_pkg::swc_cfg_t cfg,
  input wire logic signed [OUT_W-1:0] speedOut,
  input wire logic servoLock,
  input wire logic reverseError,
  input wire logic disconnectError,
  input wire logic testDone
);
  import swc_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  sequence quiet;
    ($stable(phaseA) && $stable(phaseB))[*4];
  endsequence
  chk_fault_out_zero: assert property (
    (reverseError || disconnectError) |-> (speedOut == '0 && !servoLock))
    else $error("output live after a wiring fault");
  chk_errors_exclusive: assert property (
    !(reverseError && disconnectError))
    else $error("both wiring errors set");
  chk_reverse_sticky: assert property (reverseError |=> reverseError)
    else $error("reverse error cleared");
  chk_disconnect_sticky: assert property (disconnectError |=> disconnectError)
    else $error("disconnect error cleared");
  chk_done_sticky: assert property (testDone |=> testDone)
    else $error("done flag cleared");
  chk_skip_clean: assert property (
    !cfg.checkEnable |-> !(reverseError || disconnectError))
    else $error("error raised with check skipped");
  chk_lock_at_done: assert property (
    $rose(testDone) |-> servoLock == !(reverseError || disconnectError))
    else $error("lock does not match verdict");
  chk_output_hold: assert property (
    (quiet ##0 (servoLock && testDone)) |=> $stable(speedOut))
    else $error("output moved without feedback");
endmodule
bind swc_servo_axis swc_servo_axis_sva #(.OUT_W(OUT_W)) swc_servo_axis_sva_i (
  .mclk(mclk), .reset_n(reset_n), .phaseA(phaseA), .phaseB(phaseB), .cfg(cfg),
  .speedOut(speedOut), .servoLock(servoLock), .reverseError(reverseError),
  .disconnectError(disconnectError), .testDone(testDone));

//--- test/swc_motor_model.sv
// Servo driver, motor and encoder model facing the axis.
`timescale 1ns/100ps
module swc_motor_model (
  input wire logic mclk,
  input wire logic signed [15:0] speedOut,
  input wire logic [1:0] mode,
  input wire logic slow,
  output logic phaseA,
  output logic phaseB
);
  logic [1:0] pos = 2'h0;
  logic [3:0] tick = 4'h0;
  logic [1:0] gray;
  assign gray = {pos[1], pos[1] ^ pos[0]};
  // Mode 1 swaps the phases, mode 2 cuts the cable to idle low.
  assign phaseA = (mode == 2'h2) ? 1'b0 : (mode == 2'h1) ? gray[0] : gray[1];
  assign phaseB = (mode == 2'h2) ? 1'b0 : (mode == 2'h1) ? gray[1] : gray[0];
  always_ff @(posedge mclk) begin
    tick <= (tick >= (slow ? 4'hb : 4'h5)) ? 4'h0 : tick + 4'h1;
    // positive command turns the shaft so that the count falls
    if (tick == 4'h0 && speedOut > 0) begin
      pos <= pos + 2'h1;
    end else if (tick == 4'h0 && speedOut < 0) begin
      pos <= pos - 2'h1;
    end
  end
endmodule

//--- test/swc_servo_axis_tb.sv
// Bench for the servo axis wiring check.
`timescale 1ns/100ps
module swc_servo_axis_tb;
  import swc_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic slow = 1'b0;
  logic [1:0] mode = 2'h0;
  logic phaseA, phaseB, servoLock, reverseError, disconnectError, testDone;
  logic signed [15:0] speedOut;
  swc_cfg_t cfg = '0;
  int errTotal = 0;
  int testsRun = 0;
  always #12.5 mclk = ~mclk;
  swc_servo_axis swc_servo_axis_i (.mclk(mclk), .reset_n(reset_n), .phaseA(phaseA),
    .phaseB(phaseB), .cfg(cfg), .speedOut(speedOut), .servoLock(servoLock),
    .reverseError(reverseError), .disconnectError(disconnectError), .testDone(testDone));
  swc_motor_model swc_motor_model_i (.mclk(mclk), .speedOut(speedOut), .mode(mode),
    .slow(slow), .phaseA(phaseA), .phaseB(phaseB));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic en, ccw, inv, input logic [1:0] m, input logic sl,
    input logic [3:0] exp, input logic [15:0] mid);
    int n;
    n = 0;
    @(posedge mclk);
    reset_n <= 1'b0;
    cfg <= '{en, ccw, inv, 24'h000008, 32'h00000096};
    mode <= m;
    slow <= sl;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (20) @(negedge mclk);
    if (m == 2'h2) check(speedOut, mid);
    while (testDone !== 1'b1 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    // Four edges of reset release and load, waitCycles plus one, then evaluation.
    check(16'(n), en ? 16'h0089 : 16'h0000);
    repeat (60) @(negedge mclk);
    check({12'h000, testDone, reverseError, disconnectError, servoLock}, {12'h000, exp});
    check(speedOut, 16'h0000);
    $display("test %0d done", testsRun);
  endtask
  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    errTotal++;
    tallyAndFinish();
  end
  initial begin
    run(1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 4'h9, 16'h0000);
    run(1'b1, 1'b1, 1'b0, 2'h0, 1'b1, 4'h9, 16'h0000);
    run(1'b1, 1'b0, 1'b0, 2'h1, 1'b0, 4'hc, 16'h0000);
    run(1'b1, 1'b0, 1'b1, 2'h1, 1'b0, 4'h9, 16'h0000);
    run(1'b1, 1'b0, 1'b0, 2'h2, 1'b0, 4'ha, 16'h0008);
    run(1'b1, 1'b1, 1'b0, 2'h2, 1'b0, 4'ha, 16'hfff8);
    run(1'b0, 1'b0, 1'b0, 2'h2, 1'b0, 4'h9, 16'h0000);
    tallyAndFinish();
  end
endmodule
